/* logic/sru_bank.sv */
// Secured register bank with lock and unlock sequence tracking
module sru_bank (
  input wire logic clock_i,
  input wire logic nrst_i,
  sru_if.dev bus,
  output logic locked_o,
  output logic [3:0] step_o,
  output logic [sru_pkg::DW-1:0] sleep_o,
  output logic [sru_pkg::DW-1:0] clkgen_o,
  output logic [sru_pkg::DW-1:0] perdis_o,
  output logic [sru_pkg::DW-1:0] rstcfg_o,
  output logic [sru_pkg::DW-1:0] syscfg_o
);
  import sru_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_S1 = 4'b0010,
    ST_S2 = 4'b0100,
    ST_OPEN = 4'b1000
  } sru_st_t;

  //////////////////////////////////////////////////////////////////////
  sru_st_t st_ff, nxt_st;
  logic init_done_ff;
  logic [DW-1:0] regs_ff [NREG];

  function automatic logic is_secured(input logic [AW-1:0] s);
    is_secured = (s == SEL_SLEEP) || (s == SEL_CLKGEN) ||
      (s == SEL_PERDIS) || (s == SEL_RSTCFG);
  endfunction : is_secured

  wire logic wr_unl = bus.wr && bus.sel == SEL_CLKGEN;
  wire logic [3:0] unl_val = bus.wdata[UNL_LSB +: UNL_W];
  wire logic is_open = st_ff == ST_OPEN;
  // Any secured write, the clock generation register included, consumes the grant
  wire logic sec_wr = bus.wr && is_secured(bus.sel);
  wire logic step_wr = wr_unl && !is_open;
  wire logic grant = is_open && bus.ext;
  wire logic full_ok = !init_done_ff || grant;
  wire logic succ = sec_wr && grant && init_done_ff;

  //////////////////////////////////////////////////////////////////////
  // Sequence tracker
  always_comb begin
    nxt_st = st_ff;
    // An access outside the range aborts, as does a wrong step write; idle gaps inside it do not
    if ((bus.wr || bus.rd) && !bus.ext) begin
      nxt_st = ST_IDLE;
    end else if (is_open) begin
      if (sec_wr) begin
        nxt_st = ST_IDLE;
      end
    end else if (step_wr) begin
      nxt_st = ST_IDLE;
      unique case (st_ff)
        ST_IDLE: begin
          if (unl_val == UNL_STEP1 && bus.cls == CLS_RMW) begin
            nxt_st = ST_S1;
          end
        end
        ST_S1: begin
          if (unl_val == UNL_STEP2 && bus.cls == CLS_MOVE) begin
            nxt_st = ST_S2;
          end
        end
        ST_S2: begin
          if (unl_val == UNL_STEP3 && bus.cls == CLS_BIT) begin
            nxt_st = ST_OPEN;
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_IDLE;
      init_done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (bus.end_of_init_instruction) begin
        init_done_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register storage
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      localparam logic [AW-1:0] SEL = AW'(gi);
      wire logic hit = bus.wr && bus.sel == SEL;
      // Primary config never opened by unlock
      wire logic ok = (SEL == SEL_SYSCFG) ? !init_done_ff : full_ok;
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          regs_ff[gi] <= REG_RST;
        end else if (hit && ok) begin
          regs_ff[gi] <= bus.wdata;
          if (SEL == SEL_CLKGEN && succ) begin
            regs_ff[gi][UNL_LSB +: UNL_W] <= UNL_RST;
          end
        end else if (SEL == SEL_CLKGEN && succ) begin
          regs_ff[gi][UNL_LSB +: UNL_W] <= UNL_RST;
        end else if (SEL == SEL_CLKGEN && hit) begin
          regs_ff[gi][UNL_LSB +: UNL_W] <= unl_val;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Unmapped selects read zero
  wire logic [DW-1:0] rd_mux =
    (bus.sel < AW'(NREG)) ? regs_ff[bus.sel] : '0;
  assign bus.rdata = rd_mux;
  assign locked_o = init_done_ff && !is_open;
  assign step_o = st_ff;
  assign syscfg_o = regs_ff[SEL_SYSCFG];
  assign sleep_o = regs_ff[SEL_SLEEP];
  assign clkgen_o = regs_ff[SEL_CLKGEN];
  assign perdis_o = regs_ff[SEL_PERDIS];
  assign rstcfg_o = regs_ff[SEL_RSTCFG];
endmodule : sru_bank

/* logic/sru_cpu.sv */
// CPU-side access port: registers one access per request
module sru_cpu (
  input wire logic clock_i,
  input wire logic nrst_i,
  sru_if.cpu bus,
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic [sru_pkg::AW-1:0] sel_i,
  input wire logic [sru_pkg::DW-1:0] wdata_i,
  input wire logic [1:0] cls_i,
  input wire logic ext_start_i,
  input wire logic end_of_init_instruction_i,
  output logic [sru_pkg::DW-1:0] rdata_o,
  output logic ext_active_o
);
  import sru_pkg::*;

  logic wr_ff, rd_ff, end_of_init_instruction_ff;
  logic [AW-1:0] sel_ff;
  logic [DW-1:0] wdata_ff, rdata_ff;
  logic [1:0] cls_ff;
  logic [2:0] ext_cnt_ff;

  //////////////////////////////////////////////////////////////////////
  // Extended range covers the next four writes
  wire logic ext_on = ext_cnt_ff != 3'h0;
  wire logic acc = req_i && !rd_i;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_cnt_ff <= 3'h0;
    end else if (ext_start_i) begin
      ext_cnt_ff <= EXT_COUNT;
    end else if (acc && ext_on) begin
      ext_cnt_ff <= ext_cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      end_of_init_instruction_ff <= 1'b0;
      sel_ff <= '0;
      wdata_ff <= '0;
      cls_ff <= 2'h0;
      rdata_ff <= '0;
    end else begin
      wr_ff <= acc;
      rd_ff <= req_i && rd_i;
      end_of_init_instruction_ff <= end_of_init_instruction_i;
      sel_ff <= sel_i;
      wdata_ff <= wdata_i;
      cls_ff <= cls_i;
      if (rd_ff) begin
        rdata_ff <= bus.rdata;
      end
    end
  end

  // Range flag travels with the registered access
  logic ext_ff;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_ff <= 1'b0;
    end else begin
      ext_ff <= ext_on && acc;
    end
  end

  assign bus.wr = wr_ff;
  assign bus.rd = rd_ff;
  assign bus.sel = sel_ff;
  assign bus.wdata = wdata_ff;
  assign bus.cls = cls_ff;
  assign bus.ext = ext_ff;
  assign bus.end_of_init_instruction = end_of_init_instruction_ff;
  assign rdata_o = rdata_ff;
  assign ext_active_o = ext_on;
endmodule : sru_cpu

/* logic/sru_if.sv */
// Access channel between CPU core and secured register bank
interface sru_if;
  import sru_pkg::*;
  logic wr;
  logic rd;
  logic [AW-1:0] sel;
  logic [DW-1:0] wdata;
  logic [1:0] cls;
  logic ext;
  logic end_of_init_instruction;
  logic [DW-1:0] rdata;
  modport dev (input wr, input rd, input sel, input wdata, input cls,
    input ext, input end_of_init_instruction, output rdata);
  modport cpu (output wr, output rd, output sel, output wdata,
    output cls, output ext, output end_of_init_instruction, input rdata);
endinterface : sru_if

/* logic/sru_pkg.sv */
// Constants and types for the secured register unlock block
package sru_pkg;
  localparam int DW = 16;
  localparam int AW = 3;
  // Register select codes on the access bus
  localparam logic [2:0] SEL_SYSCFG = 3'h0;
  localparam logic [2:0] SEL_SLEEP = 3'h1;
  localparam logic [2:0] SEL_CLKGEN = 3'h2;
  localparam logic [2:0] SEL_PERDIS = 3'h3;
  localparam logic [2:0] SEL_RSTCFG = 3'h4;
  localparam int NREG = 5;
  // Unlock field position in the clock generation register
  localparam int UNL_LSB = 0;
  localparam int UNL_W = 4;
  localparam logic [3:0] UNL_RST = 4'h0;
  localparam logic [3:0] UNL_STEP1 = 4'h9;
  localparam logic [3:0] UNL_STEP2 = 4'h3;
  localparam logic [3:0] UNL_STEP3 = 4'h7;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [2:0] EXT_COUNT = 3'h4;
  // Instruction class that marks each write
  typedef enum logic [1:0] {
    CLS_MOVE = 2'h0,
    CLS_RMW = 2'h1,
    CLS_BIT = 2'h2
  } sru_cls_t;
endpackage : sru_pkg

/* verif/secured_register_unlock_tb.sv */
// Bench joining CPU port and register bank through the access channel
module secured_register_unlock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sru_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req, rd, ext_start, end_of_init_instruction, locked, ext_active;
  logic [AW-1:0] sel;
  logic [DW-1:0] wdata, rdata, sleep, clkgen, perdis, rstcfg, syscfg;
  logic [1:0] cls;
  logic [3:0] step;
  int fails = 0;
  int num_checks = 0;
  sru_if bus ();
  initial forever #5 clock_i = ~clock_i;
  sru_cpu sru_cpu_i (.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus),
    .req_i(req), .rd_i(rd), .sel_i(sel), .wdata_i(wdata), .cls_i(cls),
    .ext_start_i(ext_start), .end_of_init_instruction_i(end_of_init_instruction), .rdata_o(rdata),
    .ext_active_o(ext_active));
  sru_bank sru_bank_i (.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus),
    .locked_o(locked), .step_o(step), .sleep_o(sleep), .clkgen_o(clkgen),
    .perdis_o(perdis), .rstcfg_o(rstcfg), .syscfg_o(syscfg));
  sru_properties sru_properties_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .wr(bus.wr), .rd(bus.rd), .sel(bus.sel), .wdata(bus.wdata),
    .ext(bus.ext), .end_of_init_instruction(bus.end_of_init_instruction), .rdata(bus.rdata));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // Word-wide accesses only, no byte variants
  task acc(input logic r, input logic [2:0] s, input logic [15:0] d,
    input logic [1:0] c);
    req <= 1'b1;
    rd <= r;
    sel <= s;
    wdata <= d;
    cls <= c;
    @(negedge clock_i);
    req <= 1'b0;
  endtask : acc
  // Full sequence; x low leaves the steps outside any extended range
  task unlock(input logic x, input logic [2:0] s, input logic [15:0] d,
    input logic [1:0] c2);
    acc(1'b0, SEL_CLKGEN, 16'h0000, CLS_MOVE);
    ext_start <= x;
    @(negedge clock_i);
    ext_start <= 1'b0;
    if (x) chk("ext_active", {15'h0000, ext_active}, 16'h0001);
    acc(1'b0, SEL_CLKGEN, 16'h0009, CLS_RMW);
    acc(1'b0, SEL_CLKGEN, 16'h0003, c2);
    acc(1'b0, SEL_CLKGEN, 16'h0007, CLS_BIT);
    acc(1'b0, s, d, CLS_MOVE);
    acc(1'b1, s, 16'h0000, CLS_MOVE);
    repeat (3) @(negedge clock_i);
  endtask : unlock
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {req, rd, ext_start, end_of_init_instruction, cls} = '0;
    sel = '0;
    wdata = '0;
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    chk("step", {12'h000, step}, 16'h0001);
    chk("locked", {15'h0000, locked}, 16'h0000);
    acc(1'b0, SEL_RSTCFG, 16'h00c3, CLS_MOVE);
    acc(1'b0, SEL_SLEEP, 16'h1234, CLS_MOVE);
    acc(1'b1, SEL_SLEEP, 16'h0000, CLS_MOVE);
    repeat (3) @(negedge clock_i);
    chk("rstcfg", rstcfg, 16'h00c3);
    chk("rdata", rdata, 16'h1234);
    end_of_init_instruction <= 1'b1;
    @(negedge clock_i);
    end_of_init_instruction <= 1'b0;
    acc(1'b0, SEL_SLEEP, 16'h5555, CLS_MOVE);
    acc(1'b1, SEL_SLEEP, 16'h0000, CLS_MOVE);
    acc(1'b0, SEL_SYSCFG, 16'h0001, CLS_MOVE);
    acc(1'b0, SEL_CLKGEN, 16'h00a5, CLS_MOVE);
    repeat (3) @(negedge clock_i);
    chk("locked", {15'h0000, locked}, 16'h0001);
    chk("sleep", sleep, 16'h1234);
    chk("syscfg", syscfg, 16'h0000);
    chk("clkgen", clkgen, 16'h0005);
    unlock(1'b1, SEL_PERDIS, 16'h00ff, CLS_MOVE);
    chk("perdis", perdis, 16'h00ff);
    chk("clkgen", clkgen, 16'h0000);
    chk("step", {12'h000, step}, 16'h0001);
    chk("rdata", rdata, 16'h00ff);
    acc(1'b0, SEL_PERDIS, 16'h0f0f, CLS_MOVE);
    repeat (3) @(negedge clock_i);
    chk("perdis", perdis, 16'h00ff);
    unlock(1'b1, SEL_PERDIS, 16'h0f0f, CLS_BIT);
    chk("perdis", perdis, 16'h00ff);
    chk("clkgen", clkgen, 16'h0007);
    unlock(1'b0, SEL_SLEEP, 16'h0abc, CLS_MOVE);
    chk("sleep", sleep, 16'h1234);
    unlock(1'b1, SEL_SYSCFG, 16'h0001, CLS_MOVE);
    chk("syscfg", syscfg, 16'h0000);
    tally_and_finish();
  end
endmodule : secured_register_unlock_tb

/* verif/sru_properties.sv */
// Concurrent checks on the channel between CPU port and register bank
module sru_properties
  import sru_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wr,
  input wire logic rd,
  input wire logic [AW-1:0] sel,
  input wire logic [DW-1:0] wdata,
  input wire logic ext,
  input wire logic end_of_init_instruction,
  input wire logic [DW-1:0] rdata
);
  logic done_ff;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) done_ff <= 1'b0;
    else if (end_of_init_instruction) done_ff <= 1'b1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////
  a_unmapped_zero: assert property (sel >= NREG |-> rdata == 16'h0000)
    else $error("unmapped select reads nonzero");
  a_reset_clear: assert property ($rose(nrst_i) |-> rdata == 16'h0000)
    else $error("register not cleared by reset");
  a_early_write: assert property (!done_ff && wr && sel != SEL_CLKGEN
    && sel < NREG ##1 sel == $past(sel) |-> rdata == $past(wdata))
    else $error("write before init did not land");
  // Ext low always aborts, so such a write can never be the granted one
  a_locked_drop: assert property (done_ff && wr && !ext
    && sel != SEL_CLKGEN && sel < NREG ##1 sel == $past(sel) |-> $stable(rdata))
    else $error("locked register changed");
  a_cfg_sealed: assert property (done_ff && wr && sel == SEL_SYSCFG
    ##1 sel == SEL_SYSCFG |-> $stable(rdata))
    else $error("primary config changed after init");
  a_field_open: assert property (done_ff && wr && !ext
    && sel == SEL_CLKGEN ##1 sel == SEL_CLKGEN
    |-> rdata == ($past(rdata) & 16'hfff0 | $past(wdata) & 16'h000f))
    else $error("unlock field not written alone");
  a_read_steady: assert property (!$past(wr) && $stable(sel)
    |-> $stable(rdata))
    else $error("read data changed without write");
  a_strobe_single: assert property (!(wr && rd))
    else $error("read and write strobes together");
  c_granted: cover property (done_ff && wr && ext && sel == SEL_PERDIS);
  c_end_of_init_instruction: cover property (end_of_init_instruction);
  c_read: cover property (rd && sel == SEL_SLEEP);
endmodule : sru_properties
